/* design/byte_rotate_unit.sv */
`timescale 1ns/1ps
module byte_rotate_unit #(
    parameter int ADDR_W = rotate_pkg::ADDR_W_DEF
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              exec_valid,
    input  wire logic [2:0]        exec_op,
    input  wire logic [ADDR_W-1:0] exec_addr,
    input  wire logic [7:0]        operand,
    input  wire logic              carry_in,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [7:0]             mem_wdata,
    output logic                   work_we,
    output logic [7:0]             working_register,
    output logic                   carry_we,
    output logic                   shift_out_bit,
    output logic                   done,
    output logic                   op_error
);

    // Elaboration check on the address width
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
        $error("byte_rotate_unit: ADDR_W must lie in 1..16");
    end

    // Bundle shared with the rotate engine
    rot_if rif ();

    // Operand and instruction into the rotate engine
    assign rif.op       = exec_op;
    assign rif.operand  = operand;
    assign rif.carry_in = carry_in;

    rotate_engine u_engine (
        .rif (rif)
    );

    // Request accepted only for a decoded code
    logic take;
    assign take = exec_valid & rif.legal;

    // Memory write-back, one cycle after the request
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= rotate_pkg::WDATA_RESET;
        end else begin
            mem_we <= take & rif.to_mem;
            if (take & rif.to_mem) begin
                mem_addr  <= exec_addr;
                mem_wdata <= rif.result;
            end
        end
    end

    // Working register load
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            work_we          <= 1'b0;
            working_register <= rotate_pkg::WORK_RESET;
        end else begin
            work_we <= take & rif.to_work;
            if (take & rif.to_work) begin
                working_register <= rif.result;
            end
        end
    end

    // Carry flag update, only for the through-carry forms
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            carry_we      <= 1'b0;
            shift_out_bit <= 1'b0;
        end else begin
            carry_we <= take & rif.writes_carry;
            if (take & rif.writes_carry) begin
                shift_out_bit <= rif.carry_out;
            end
        end
    end

    // Completion and bad-code pulses
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            done     <= 1'b0;
            op_error <= 1'b0;
        end else begin
            done     <= take;
            op_error <= exec_valid & ~rif.legal;
        end
    end

    // Checks on the datapath
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_ROL_MEM: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_IN_PLACE
        |=> mem_we && !work_we && !carry_we
            && mem_wdata == {$past(operand[6:0]), $past(operand[7])}
            && mem_addr == $past(exec_addr))
        else $error("left rotate in place wrong");

    AST_ROL_WORK: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_TO_WORK
        |=> work_we && !mem_we && !carry_we
            && working_register == {$past(operand[6:0]), $past(operand[7])})
        else $error("left rotate to working register wrong");

    AST_ROLC_MEM: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_CARRY_IN_PLACE
        |=> mem_we && carry_we && !work_we
            && mem_wdata == {$past(operand[6:0]), $past(carry_in)}
            && shift_out_bit == $past(operand[7]))
        else $error("left rotate through carry in place wrong");

    AST_ROLC_WORK: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_CARRY_TO_WORK
        |=> work_we && carry_we && !mem_we
            && working_register == {$past(operand[6:0]), $past(carry_in)}
            && shift_out_bit == $past(operand[7]))
        else $error("left rotate through carry to working register wrong");

    AST_ROR_MEM: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_IN_PLACE
        |=> mem_we && !carry_we && !work_we
            && mem_wdata == {$past(operand[0]), $past(operand[7:1])})
        else $error("right rotate in place wrong");

    AST_ROR_WORK: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_TO_WORK
        |=> work_we && !mem_we && !carry_we && $stable(shift_out_bit)
            && working_register == {$past(operand[0]), $past(operand[7:1])})
        else $error("right rotate to working register wrong");

    AST_RORC_MEM: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_CARRY_IN_PLACE
        |=> mem_we && carry_we && !work_we
            && mem_wdata == {$past(carry_in), $past(operand[7:1])}
            && shift_out_bit == $past(operand[0]))
        else $error("right rotate through carry in place wrong");

    AST_ONE_STEP: assert property (
        exec_valid && exec_op != rotate_pkg::ROTATE_UNUSED
        |=> done ##1 (!done || $past(exec_valid)))
        else $error("rotate did not finish in one step");

    AST_BAD_CODE: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_UNUSED
        |=> op_error && !done && !mem_we && !work_we && !carry_we)
        else $error("unused code produced a write");

    AST_IDLE_QUIET: assert property (
        !exec_valid |=> !mem_we && !work_we && !carry_we && !done
            && $stable(working_register) && $stable(shift_out_bit))
        else $error("write without a request");

    // Bystander state left alone by each form
    AST_ROL_MEM_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_IN_PLACE
        |=> $stable(shift_out_bit) && $stable(working_register))
        else $error("left rotate in place touched other state");

    AST_ROL_WORK_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_TO_WORK
        |=> $stable(mem_wdata) && $stable(mem_addr) && $stable(shift_out_bit))
        else $error("left rotate to working register touched other state");

    AST_ROLC_MEM_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_CARRY_IN_PLACE
        |=> mem_addr == $past(exec_addr) && $stable(working_register))
        else $error("left rotate through carry in place touched other state");

    AST_ROLC_WORK_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_CARRY_TO_WORK
        |=> $stable(mem_wdata) && $stable(mem_addr))
        else $error("left rotate through carry to working register touched memory");

    AST_ROR_MEM_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_IN_PLACE
        |=> mem_addr == $past(exec_addr)
            && $stable(shift_out_bit) && $stable(working_register))
        else $error("right rotate in place touched other state");

    AST_ROR_WORK_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_TO_WORK
        |=> $stable(mem_wdata) && $stable(mem_addr))
        else $error("right rotate to working register touched memory");

    AST_RORC_MEM_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_CARRY_IN_PLACE
        |=> mem_addr == $past(exec_addr) && $stable(working_register))
        else $error("right rotate through carry in place touched other state");

    AST_BAD_CODE_KEEP: assert property (
        exec_valid && exec_op == rotate_pkg::ROTATE_UNUSED
        |=> $stable(mem_wdata) && $stable(mem_addr)
            && $stable(working_register) && $stable(shift_out_bit))
        else $error("unused code changed held data");

    // Strobe consistency on every cycle
    AST_ONE_DEST: assert property (
        (mem_we || work_we) |-> done && !(mem_we && work_we))
        else $error("write strobe without a single destination");

    AST_CARRY_WITH_DONE: assert property (
        carry_we |-> done && !op_error)
        else $error("carry update outside a finished rotate");

    AST_ERROR_ALONE: assert property (
        op_error |-> !done && !mem_we && !work_we && !carry_we)
        else $error("error pulse together with a write");

    COV_LEFT_CARRY: cover property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_CARRY_IN_PLACE && carry_in && !operand[7]);
    COV_RIGHT_WORK: cover property (
        exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_TO_WORK ##1 done);
    COV_BACK_TO_BACK: cover property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_CARRY_TO_WORK
        ##1 exec_valid && exec_op == rotate_pkg::ROTATE_RIGHT_CARRY_IN_PLACE);
    COV_BAD_CODE: cover property (
        exec_valid && exec_op == rotate_pkg::ROTATE_UNUSED ##1 op_error);
    COV_LEFT_WORK: cover property (
        exec_valid && exec_op == rotate_pkg::ROTATE_LEFT_TO_WORK ##1 work_we);

endmodule : byte_rotate_unit

/* design/rotate_pkg.sv */
package rotate_pkg;

    // Operand geometry
    localparam int DATA_W     = 8;
    localparam int TOP_BIT    = 7;
    localparam int LOW_BIT    = 0;
    localparam int OP_W       = 3;
    localparam int ADDR_W_DEF = 8;

    // Reset values
    localparam logic [7:0] WORK_RESET  = 8'h00;
    localparam logic [7:0] WDATA_RESET = 8'h00;

    // Instruction codes presented by the decoder
    typedef enum logic [2:0] {
        ROTATE_LEFT_IN_PLACE        = 3'h0,
        ROTATE_LEFT_TO_WORK         = 3'h1,
        ROTATE_LEFT_CARRY_IN_PLACE  = 3'h2,
        ROTATE_LEFT_CARRY_TO_WORK   = 3'h3,
        ROTATE_RIGHT_IN_PLACE       = 3'h4,
        ROTATE_RIGHT_TO_WORK        = 3'h5,
        ROTATE_RIGHT_CARRY_IN_PLACE = 3'h6,
        ROTATE_UNUSED               = 3'h7
    } rot_op_e;

    // Left shift by one with a chosen bit entering at the bottom
    function automatic logic [7:0] shift_left_in(input logic [7:0] value, input logic fill);
        shift_left_in = {value[TOP_BIT-1:LOW_BIT], fill};
    endfunction : shift_left_in

    // Right shift by one with a chosen bit entering at the top
    function automatic logic [7:0] shift_right_in(input logic [7:0] value, input logic fill);
        shift_right_in = {fill, value[TOP_BIT:LOW_BIT+1]};
    endfunction : shift_right_in

endpackage : rotate_pkg

/* design/rot_if.sv */
`timescale 1ns/1ps
interface rot_if;
    logic [2:0] op;
    logic [7:0] operand;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       to_mem;
    logic       to_work;
    logic       writes_carry;
    logic       legal;

    modport calc (
        input  op,
        input  operand,
        input  carry_in,
        output result,
        output carry_out,
        output to_mem,
        output to_work,
        output writes_carry,
        output legal
    );

    modport user (
        output op,
        output operand,
        output carry_in,
        input  result,
        input  carry_out,
        input  to_mem,
        input  to_work,
        input  writes_carry,
        input  legal
    );
endinterface : rot_if

/* design/rotate_engine.sv */
`timescale 1ns/1ps
module rotate_engine (
    rot_if.calc rif
);

    // Combinational rotate and destination decode
    always_comb begin
        rif.result       = rif.operand;
        rif.carry_out    = rif.carry_in;
        rif.to_mem       = 1'b0;
        rif.to_work      = 1'b0;
        rif.writes_carry = 1'b0;
        rif.legal        = 1'b1;
        case (rif.op)
            rotate_pkg::ROTATE_LEFT_IN_PLACE: begin
                rif.result = rotate_pkg::shift_left_in(rif.operand, rif.operand[rotate_pkg::TOP_BIT]);
                rif.to_mem = 1'b1;
            end
            rotate_pkg::ROTATE_LEFT_TO_WORK: begin
                rif.result  = rotate_pkg::shift_left_in(rif.operand, rif.operand[rotate_pkg::TOP_BIT]);
                rif.to_work = 1'b1;
            end
            rotate_pkg::ROTATE_LEFT_CARRY_IN_PLACE: begin
                rif.result       = rotate_pkg::shift_left_in(rif.operand, rif.carry_in);
                rif.carry_out    = rif.operand[rotate_pkg::TOP_BIT];
                rif.writes_carry = 1'b1;
                rif.to_mem       = 1'b1;
            end
            rotate_pkg::ROTATE_LEFT_CARRY_TO_WORK: begin
                rif.result       = rotate_pkg::shift_left_in(rif.operand, rif.carry_in);
                rif.carry_out    = rif.operand[rotate_pkg::TOP_BIT];
                rif.writes_carry = 1'b1;
                rif.to_work      = 1'b1;
            end
            rotate_pkg::ROTATE_RIGHT_IN_PLACE: begin
                rif.result = rotate_pkg::shift_right_in(rif.operand, rif.operand[rotate_pkg::LOW_BIT]);
                rif.to_mem = 1'b1;
            end
            rotate_pkg::ROTATE_RIGHT_TO_WORK: begin
                rif.result  = rotate_pkg::shift_right_in(rif.operand, rif.operand[rotate_pkg::LOW_BIT]);
                rif.to_work = 1'b1;
            end
            rotate_pkg::ROTATE_RIGHT_CARRY_IN_PLACE: begin
                rif.result       = rotate_pkg::shift_right_in(rif.operand, rif.carry_in);
                rif.carry_out    = rif.operand[rotate_pkg::LOW_BIT];
                rif.writes_carry = 1'b1;
                rif.to_mem       = 1'b1;
            end
            default: begin
                rif.legal = 1'b0;
            end
        endcase
    end

endmodule : rotate_engine

/* tb/tb_byte_rotate_unit.sv */
`timescale 1ns/1ps
module tb_byte_rotate_unit;
    logic       ref_clk    = 1'b0;
    logic       resetn     = 1'b0;
    logic       exec_valid = 1'b0;
    logic [2:0] exec_op    = 3'h0;
    logic [7:0] exec_addr  = 8'h00;
    logic [7:0] operand    = 8'h00;
    logic       carry_in   = 1'b0;
    logic       mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic       work_we;
    logic [7:0] working_register;
    logic       carry_we;
    logic       shift_out_bit;
    logic       done;
    logic       op_error;
    int         n_fail      = 0;
    int         comparisons = 0;
    logic [7:0] exp_addr    = 8'h00;
    logic [7:0] exp_wdata   = 8'h00;
    logic [7:0] exp_work    = 8'h00;
    logic       exp_sob     = 1'b0;

    // Free-running 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    byte_rotate_unit #(.ADDR_W(8)) i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .exec_valid(exec_valid), .exec_op(exec_op),
        .exec_addr(exec_addr), .operand(operand), .carry_in(carry_in), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .work_we(work_we),
        .working_register(working_register), .carry_we(carry_we), .shift_out_bit(shift_out_bit),
        .done(done), .op_error(op_error)
    );

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Issue one request at a falling edge, judge the answer one cycle later
    task automatic run_op(input logic [2:0] op, input logic [7:0] addr, input logic [7:0] opnd,
                          input logic cin);
        logic [7:0] res;
        logic [4:0] stb;
        exec_valid = 1'b1;
        exec_op    = op;
        exec_addr  = addr;
        operand    = opnd;
        carry_in   = cin;
        @(negedge ref_clk);
        res = 8'h00;
        case (op)
            3'h0: begin res = {opnd[6:0], opnd[7]}; stb = 5'b10010; end
            3'h1: begin res = {opnd[6:0], opnd[7]}; stb = 5'b01010; end
            3'h2: begin res = {opnd[6:0], cin}; stb = 5'b10110; exp_sob = opnd[7]; end
            3'h3: begin res = {opnd[6:0], cin}; stb = 5'b01110; exp_sob = opnd[7]; end
            3'h4: begin res = {opnd[0], opnd[7:1]}; stb = 5'b10010; end
            3'h5: begin res = {opnd[0], opnd[7:1]}; stb = 5'b01010; end
            3'h6: begin res = {cin, opnd[7:1]}; stb = 5'b10110; exp_sob = opnd[0]; end
            default: stb = 5'b00001;
        endcase
        if (stb[4]) begin
            exp_addr  = addr;
            exp_wdata = res;
        end
        if (stb[3]) exp_work = res;
        check(8'({mem_we, work_we, carry_we, done, op_error}), 8'(stb), "strobes");
        check(mem_wdata, exp_wdata, "memory data");
        check(mem_addr, exp_addr, "memory address");
        check(working_register, exp_work, "working register");
        check(8'(shift_out_bit), 8'(exp_sob), "carry out");
    endtask : run_op

    // Quiet cycles: no strobes, data held
    task automatic idle(input int cycles);
        exec_valid = 1'b0;
        repeat (cycles) begin
            @(negedge ref_clk);
            check(8'({mem_we, work_we, carry_we, done, op_error}), 8'h00, "idle strobes");
            check(mem_wdata, exp_wdata, "held memory data");
            check(working_register, exp_work, "held working register");
            check(8'(shift_out_bit), 8'(exp_sob), "held carry");
        end
    endtask : idle

    // Every legal code (0 to 6) with both carry levels and patterns 81 and 7e
    task automatic t_all_ops();
        for (int op = 0; op < 7; op++) begin
            run_op(3'(op), 8'h10 + 8'(op), 8'h81, 1'b0);
            run_op(3'(op), 8'h20 + 8'(op), 8'h7e, 1'b1);
        end
        idle(1);
        $display("test all_ops done");
    endtask : t_all_ops

    // Back-to-back requests, caller forwards the carry
    task automatic t_back_to_back();
        run_op(3'h2, 8'hff, 8'h80, 1'b0);
        run_op(3'h5, 8'h00, 8'h01, 1'b0);
        run_op(3'h3, 8'h01, 8'h01, 1'b1);
        run_op(3'h6, 8'h02, 8'h01, 1'b0);
        run_op(3'h1, 8'h03, 8'h00, 1'b1);
        idle(2);
        $display("test back_to_back done");
    endtask : t_back_to_back

    // Unused code between legal ones raises op_error and leaves all other outputs alone
    task automatic t_refused();
        run_op(3'h4, 8'h55, 8'h03, 1'b0);
        run_op(3'h7, 8'haa, 8'hff, 1'b1);
        run_op(3'h0, 8'h56, 8'hc0, 1'b0);
        idle(1);
        $display("test refused done");
    endtask : t_refused

    // Reset in mid-run clears all outputs
    task automatic t_reset_mid();
        run_op(3'h3, 8'h77, 8'hf0, 1'b1);
        exec_valid = 1'b0;
        resetn     = 1'b0;
        @(negedge ref_clk);
        exp_addr  = 8'h00;
        exp_wdata = 8'h00;
        exp_work  = 8'h00;
        exp_sob   = 1'b0;
        check(mem_addr, 8'h00, "reset address");
        resetn = 1'b1;
        idle(1);
        run_op(3'h6, 8'h09, 8'h01, 1'b1);
        idle(1);
        $display("test reset_mid done");
    endtask : t_reset_mid

    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the expected run length
    initial begin
        #(2000 * 8);
        n_fail++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        idle(1);
        $display("test reset_values done");
        t_all_ops();
        t_back_to_back();
        t_refused();
        t_reset_mid();
        wrap_up();
    end
endmodule : tb_byte_rotate_unit
